/* File: btg_top.sv */
// buzzer tone generator with an AXI4-Lite register port
`timescale 1ns/1ns
`default_nettype none
`include "btg_map.svh"

// Functional notes
// R1: normal mode: tone follows output-on bit
// R2: one-shot: write 1 starts timed burst
// R3: one-shot: on bit reads 1 during burst
// R4: one-shot: write 0 stops burst at once
// R5: one-shot: write 1 restarts full duration
// R6: envelope: start at level 1, step down
// R7: envelope: stop after reaching level 8
// R8: envelope: on bit reads running state
// R9: envelope: write 0 stops at once
// R10: envelope: write 1 restarts at maximum
// R11: 3-bit frequency code, 4096 Hz at 0
// R12: volume code sets high counts per group
// R13: period of 16/20/24/28 steps by group
// R14: envelope ignores software volume code
// R15: output-on bit is 0 after reset
// R16: mode field: normal, one-shot, envelope
// R17: duration field: 15.63 to 125 ms
// R18: clock gate bit enables tone clock
// R19: reserved bits read 0; idle output low
// R20: code changes apply at period boundary
module btg_top
  import btg_pkg::*;
#(
  parameter int          STEP_DIV = `BTG_STEP_DIV  // system clocks per 65536 Hz step tick
) (
  input  wire logic        mclk_i,        // 250 MHz system clock
  input  wire logic        rst_i,         // asynchronous reset, active high
  input  wire logic [31:0] s_awaddr_i,    // write address
  input  wire logic        s_awvalid_i,   // write address valid
  output logic             s_awready_o,   // write address ready
  input  wire logic [31:0] s_wdata_i,     // write data
  input  wire logic [3:0]  s_wstrb_i,     // write byte strobes
  input  wire logic        s_wvalid_i,    // write data valid
  output logic             s_wready_o,    // write data ready
  output logic [1:0]       s_bresp_o,     // write response
  output logic             s_bvalid_o,    // write response valid
  input  wire logic        s_bready_i,    // write response ready
  input  wire logic [31:0] s_araddr_i,    // read address
  input  wire logic        s_arvalid_i,   // read address valid
  output logic             s_arready_o,   // read address ready
  output logic [31:0]      s_rdata_o,     // read data
  output logic [1:0]       s_rresp_o,     // read response
  output logic             s_rvalid_o,    // read data valid
  input  wire logic        s_rready_i,    // read data ready
  output logic             buzzer_o       // buzzer drive, idles low
);

  // ==========================================================
  // decode helpers
  function automatic btg_sel_t reg_sel(input logic [15:0] idx);
    case (idx)
      `BTG_IDX_CLOCK_GATE: reg_sel = BTG_SEL_GATE;
      `BTG_IDX_CONTROL:    reg_sel = BTG_SEL_CTRL;
      `BTG_IDX_FREQ:       reg_sel = BTG_SEL_FREQ;
      `BTG_IDX_VOLUME:     reg_sel = BTG_SEL_VOL;
      default:             reg_sel = BTG_SEL_NONE;
    endcase
  endfunction : reg_sel

  // only aligned words inside the 18-bit byte address space map onto registers
  function automatic logic [15:0] addr_idx(input logic [31:0] a);
    addr_idx = ((a[31:18] == 14'h0000) && (a[1:0] == 2'h0)) ? a[17:2] : 16'h0000;
  endfunction : addr_idx

  // steps in one tone period: 16, 20, 24 or 28
  function automatic logic [4:0] period_len(input logic [2:0] f);
    period_len = `BTG_PERIOD_BASE + 5'(`BTG_PERIOD_INC * f[1:0]);  // R13
  endfunction : period_len

  // high steps: level 1 count less one per level
  function automatic logic [4:0] high_len(input logic [2:0] f, input logic [2:0] lvl);
    logic [4:0] top;
    top = f[1] ? `BTG_HIGH_LONG : `BTG_HIGH_SHORT;
    high_len = top - {2'h0, lvl};  // R12
  endfunction : high_len

  // ==========================================================
  // state
  btg_state_s_t s;
  btg_state_s_t next_s;

  logic       tick;
  logic       step_tick;
  logic       period_end;
  logic       dur_end;
  logic       do_write;
  logic       start;
  logic       stop;
  logic [2:0] lvl_src;
  logic [13:0] dur_limit;
  btg_sel_t   wsel;
  btg_sel_t   rsel;

  assign s_awready_o = !s.aw_hold && !s.bvalid;
  assign s_wready_o  = !s.w_hold && !s.bvalid;
  assign s_arready_o = !s.rvalid;
  assign s_bvalid_o  = s.bvalid;
  assign s_bresp_o   = s.bresp;
  assign s_rvalid_o  = s.rvalid;
  assign s_rresp_o   = s.rresp;
  assign s_rdata_o   = {24'h000000, s.rdata};
  assign buzzer_o    = s.tone;

  always_comb begin
    next_s = s;

    // ==========================================================
    // bus slave: write address and data may arrive in either order
    if (s_awvalid_i && s_awready_o) begin
      next_s.aw_hold = 1'b1;
      next_s.aw_idx  = addr_idx(s_awaddr_i);
    end
    if (s_wvalid_i && s_wready_o) begin
      next_s.w_hold  = 1'b1;
      next_s.w_data  = s_wdata_i[7:0];
      next_s.w_lane0 = s_wstrb_i[0];
    end
    wsel     = reg_sel(s.aw_idx);
    do_write = s.aw_hold && s.w_hold && !s.bvalid;
    start    = 1'b0;
    stop     = 1'b0;
    if (do_write) begin
      next_s.aw_hold = 1'b0;
      next_s.w_hold  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = (wsel == BTG_SEL_NONE) ? `BTG_RESP_DECERR : `BTG_RESP_OKAY;
      if (s.w_lane0) begin
        // reserved bits are dropped here, so they always read back as zero
        case (wsel)
          BTG_SEL_GATE: next_s.clk_gate = s.w_data[`BTG_GATE_BIT];  // R18 R19
          BTG_SEL_CTRL: begin
            next_s.mode = s.w_data[`BTG_MODE_LSB +: 2];  // R16
            next_s.dur  = s.w_data[`BTG_DUR_LSB +: 2];   // R17
            start = s.w_data[`BTG_ON_BIT];
            stop  = !s.w_data[`BTG_ON_BIT];
          end
          BTG_SEL_FREQ: next_s.fsel = s.w_data[`BTG_CODE_LSB +: 3];  // R11 R19
          BTG_SEL_VOL:  next_s.vsel = s.w_data[`BTG_CODE_LSB +: 3];  // R12 R19
          default: ;
        endcase
      end
    end
    if (s.bvalid && s_bready_i) begin
      next_s.bvalid = 1'b0;
    end

    rsel = reg_sel(addr_idx(s_araddr_i));
    if (s_arvalid_i && s_arready_o) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = (rsel == BTG_SEL_NONE) ? `BTG_RESP_DECERR : `BTG_RESP_OKAY;
      case (rsel)
        BTG_SEL_GATE: next_s.rdata = {7'h00, s.clk_gate};
        BTG_SEL_CTRL: next_s.rdata = {2'h0, s.dur, s.mode, 1'b0, s.st == BTG_TONE};  // R3 R8
        BTG_SEL_FREQ: next_s.rdata = {5'h00, s.fsel};  // R19
        BTG_SEL_VOL:  next_s.rdata = {5'h00, s.vsel};  // R19
        default:      next_s.rdata = 8'h00;
      endcase
    end else if (s.rvalid && s_rready_i) begin
      next_s.rvalid = 1'b0;
    end

    // ==========================================================
    // step clock: the tone runs only while the clock gate is set
    tick = 1'b0;
    if (s.clk_gate) begin  // R18
      if (s.div_cnt == 12'(STEP_DIV - 1)) begin
        next_s.div_cnt = 12'h000;
        tick = 1'b1;
      end else begin
        next_s.div_cnt = s.div_cnt + 12'h001;
      end
    end
    if (tick) begin
      next_s.half = !s.half;
    end
    // codes 4 to 7 run the period steps at half rate
    step_tick  = tick && (!s.act_f[2] || s.half);  // R11
    period_end = step_tick && (s.step == period_len(s.act_f) - 5'h01);

    // ==========================================================
    // tone period and burst timing
    lvl_src   = (s.mode == `BTG_MODE_ENVELOPE) ? s.env_lvl : s.vsel;  // R14
    dur_limit = `BTG_DUR_BASE_TICKS << s.dur;  // R17
    dur_end   = tick && (s.dur_cnt == dur_limit - 14'h0001);

    case (s.st)
      BTG_IDLE: begin
        next_s.step = 5'h00;
      end
      BTG_TONE: begin
        if (step_tick) begin
          next_s.step = period_end ? 5'h00 : s.step + 5'h01;
        end
        if (period_end) begin
          // new codes are taken only between periods so no period is cut short
          next_s.act_f   = s.fsel;     // R20
          next_s.act_lvl = lvl_src;    // R20
        end
        if (tick) begin
          next_s.dur_cnt = dur_end ? 14'h0000 : s.dur_cnt + 14'h0001;
        end
        if (dur_end) begin
          case (s.mode)
            `BTG_MODE_ONESHOT: next_s.st = BTG_IDLE;  // R2 R3
            `BTG_MODE_ENVELOPE: begin
              if (s.env_lvl == `BTG_ENV_LAST_LVL) begin
                next_s.st = BTG_IDLE;  // R7 R8
              end else begin
                next_s.env_lvl = s.env_lvl + 3'h1;  // R6
              end
            end
            default: ;  // R1
          endcase
        end
      end
      default: next_s.st = BTG_IDLE;
    endcase

    // software write comes last so a start beats a burst ending in the same cycle
    if (stop) begin
      next_s.st = BTG_IDLE;  // R1 R4 R9
    end
    if (start) begin
      next_s.st      = BTG_TONE;  // R1 R2 R5 R10
      next_s.step    = 5'h00;
      next_s.half    = 1'b0;
      next_s.dur_cnt = 14'h0000;  // R5
      next_s.env_lvl = 3'h0;      // R6 R10
      next_s.act_f   = s.fsel;
      next_s.act_lvl = (s.w_data[`BTG_MODE_LSB +: 2] == `BTG_MODE_ENVELOPE) ? 3'h0 : s.vsel;  // R10 R14
    end

    // output is low whenever no tone is produced
    next_s.tone = (next_s.st == BTG_TONE) && s.clk_gate &&
                  (next_s.step < high_len(next_s.act_f, next_s.act_lvl));  // R1 R12 R19
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s          <= '0;
      s.st       <= BTG_IDLE;  // R15
      s.mode     <= `BTG_RST_MODE;
      s.dur      <= `BTG_RST_DUR;
      s.fsel     <= `BTG_RST_CODE;
      s.vsel     <= `BTG_RST_CODE;
      s.clk_gate <= 1'b0;  // R18
    end else begin
      s <= next_s;
    end
  end

endmodule : btg_top
`default_nettype wire

/* File: btg_map.svh */
// register map, field positions, reset values and timing counts of the buzzer tone generator
`ifndef BTG_MAP_SVH
`define BTG_MAP_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define BTG_IDX_CLOCK_GATE 16'h506e
`define BTG_IDX_CONTROL    16'h5180
`define BTG_IDX_FREQ       16'h5181
`define BTG_IDX_VOLUME     16'h5182

// ==========================================================
// field positions
`define BTG_ON_BIT         0
`define BTG_MODE_LSB       2
`define BTG_DUR_LSB        4
`define BTG_CODE_LSB       0
`define BTG_GATE_BIT       0

// ==========================================================
// reset values
`define BTG_RST_MODE       2'h0
`define BTG_RST_DUR        2'h0
`define BTG_RST_CODE       3'h0

// ==========================================================
// mode codes
`define BTG_MODE_NORMAL    2'h0
`define BTG_MODE_ONESHOT   2'h1
`define BTG_MODE_ENVELOPE  2'h2

// ==========================================================
// timing: step clock of the tone period, and durations in step ticks
`define BTG_MCLK_HZ        250000000
`define BTG_STEP_HZ        65536
`define BTG_STEP_DIV       (`BTG_MCLK_HZ / `BTG_STEP_HZ)
`define BTG_DUR_MS_BASE    15.63
`define BTG_DUR_BASE_TICKS 14'h0400
`define BTG_ENV_LAST_LVL   3'h7

// ==========================================================
// duty table: level 1 high counts per frequency group, period base and increment
`define BTG_HIGH_SHORT     5'h08
`define BTG_HIGH_LONG      5'h0c
`define BTG_PERIOD_BASE    5'h10
`define BTG_PERIOD_INC     5'h04

// ==========================================================
// bus answers
`define BTG_RESP_OKAY      2'h0
`define BTG_RESP_DECERR    2'h3

`endif

/* File: btg_pkg.sv */
// types of the buzzer tone generator
package btg_pkg;

  // ==========================================================
  // burst state
  typedef enum logic [0:0] {
    BTG_IDLE,
    BTG_TONE
  } btg_state_t;

  // register selector returned by the address decoder
  typedef enum logic [2:0] {
    BTG_SEL_NONE,
    BTG_SEL_GATE,
    BTG_SEL_CTRL,
    BTG_SEL_FREQ,
    BTG_SEL_VOL
  } btg_sel_t;

  // ==========================================================
  // complete state of the block
  typedef struct packed {
    logic        aw_hold;
    logic [15:0] aw_idx;
    logic        w_hold;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [7:0]  rdata;
    logic        clk_gate;
    logic [1:0]  mode;
    logic [1:0]  dur;
    logic [2:0]  fsel;
    logic [2:0]  vsel;
    btg_state_t  st;
    logic [11:0] div_cnt;
    logic        half;
    logic [4:0]  step;
    logic [2:0]  act_f;
    logic [2:0]  act_lvl;
    logic [2:0]  env_lvl;
    logic [13:0] dur_cnt;
    logic        tone;
  } btg_state_s_t;

endpackage : btg_pkg

/* File: btg_props.sv */
// bound checker of the buzzer tone generator bus and buzzer output
`timescale 1ns/1ns
`default_nettype none
`include "btg_map.svh"
module btg_props #(
  parameter int STEP_DIV = 4  // clocks per step tick
) (
  input wire logic        mclk_i,      // clock
  input wire logic        rst_i,       // reset
  input wire logic [31:0] s_awaddr_i,  // aw addr
  input wire logic        s_awvalid_i, // aw valid
  input wire logic        s_awready_o, // aw ready
  input wire logic [31:0] s_wdata_i,   // w data
  input wire logic [3:0]  s_wstrb_i,   // w strobe
  input wire logic        s_wvalid_i,  // w valid
  input wire logic        s_wready_o,  // w ready
  input wire logic        s_bvalid_o,  // b valid
  input wire logic        s_bready_i,  // b ready
  input wire logic        s_arvalid_i, // ar valid
  input wire logic        s_arready_o, // ar ready
  input wire logic [31:0] s_rdata_o,   // r data
  input wire logic        s_rvalid_o,  // r valid
  input wire logic        s_rready_i,  // r ready
  input wire logic        buzzer_o     // tone
);
  // ==========================================================
  // helpers
  wire logic wboth = s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o;
  wire logic stop = wboth && s_awaddr_i == {14'h0, `BTG_IDX_CONTROL, 2'h0} && s_wstrb_i[0] && !s_wdata_i[0];
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // properties
  property p_idle; $fell(rst_i) |-> !buzzer_o && s_awready_o && s_arready_o; endproperty
  a_idle: assert property (p_idle) else $error("not idle after reset");
  property p_hold_b; s_bvalid_o && !s_bready_i |=> s_bvalid_o; endproperty
  a_hold_b: assert property (p_hold_b) else $error("write answer dropped");
  property p_hold_r; s_rvalid_o && !s_rready_i |=> s_rvalid_o && $stable(s_rdata_o); endproperty
  a_hold_r: assert property (p_hold_r) else $error("read answer dropped");
  property p_rsvd; s_rvalid_o |-> s_rdata_o[31:8] == 24'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("upper read bits set");
  property p_wr_ans; wboth |-> ##[1:2] s_bvalid_o; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
  property p_rd_ans; s_arvalid_i && s_arready_o |=> s_rvalid_o; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
  property p_b_busy; s_bvalid_o |-> !s_awready_o && !s_wready_o; endproperty
  a_b_busy: assert property (p_b_busy) else $error("write taken while busy");
  property p_stop; stop |-> ##[2:3] !buzzer_o [*8]; endproperty
  a_stop: assert property (p_stop) else $error("tone not stopped");
endmodule : btg_props
bind btg_top btg_props #(.STEP_DIV(STEP_DIV)) btg_props_inst (.*);
`default_nettype wire

/* File: btg_piezo.sv */
// buzzer model: measures high time and period of the drive signal
`timescale 1ns/1ns
`default_nettype none
module btg_piezo (
  input  wire logic        clk_i,   // sampling clock
  input  wire logic        drive_i, // buzzer drive
  output logic      [31:0] hi_o,    // high clocks of last period
  output logic      [31:0] per_o,   // clocks of last period
  output logic      [31:0] rises_o  // rising edges seen
);
  logic        prev;
  logic [31:0] cnt;
  logic [31:0] hcnt;
  initial begin
    {prev, cnt, hcnt, hi_o, per_o, rises_o} = '0;
  end
  // a piezo only moves on edges, so the model counts whole periods
  always @(posedge clk_i) begin
    prev <= drive_i;
    if (drive_i && !prev) begin
      per_o <= cnt;
      hi_o <= hcnt;
      cnt <= 32'h1;
      hcnt <= 32'h1;
      rises_o <= rises_o + 32'h1;
    end else begin
      cnt <= cnt + 32'h1;
      hcnt <= hcnt + {31'h0, drive_i};
    end
  end
endmodule : btg_piezo
`default_nettype wire

/* File: tb_buzzer_tone_generator.sv */
// testbench of the buzzer tone generator
`timescale 1ns/1ns
`default_nettype none
`include "btg_map.svh"
module tb_buzzer_tone_generator;
  localparam int SD = 4;
  localparam logic [15:0] CTL = `BTG_IDX_CONTROL, FRQ = `BTG_IDX_FREQ, VOL = `BTG_IDX_VOLUME;
  localparam logic [15:0] GTE = `BTG_IDX_CLOCK_GATE;
  localparam logic [1:0] OK = `BTG_RESP_OKAY, DE = `BTG_RESP_DECERR;
  logic mclk_i = 0, rst_i = 1, s_awvalid_i = 0, s_wvalid_i = 0, s_bready_i = 0, s_arvalid_i = 0, s_rready_i = 0;
  logic [31:0] s_awaddr_i = 0, s_wdata_i = 0, s_araddr_i = 0;
  logic [3:0] s_wstrb_i = 4'h1;
  wire logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o, buzzer_o;
  wire logic [1:0] s_bresp_o, s_rresp_o;
  wire logic [31:0] s_rdata_o, hi, per, rises;
  int errors = 0, compares = 0;
  btg_top #(.STEP_DIV(SD)) btg_top_inst (.*);
  btg_piezo btg_piezo_inst (.clk_i(mclk_i), .drive_i(buzzer_o), .hi_o(hi), .per_o(per), .rises_o(rises));
  always #2 mclk_i = ~mclk_i;
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : cyc
  // handshakes are sampled at the rising edge, before the design's registers move
  task automatic wr(input logic [15:0] i, input logic [7:0] d, input logic [1:0] er);
    logic b;
    logic [1:0] r;
    s_awaddr_i <= {14'h0, i, 2'h0};
    s_wdata_i <= {24'h0, d};
    s_awvalid_i <= 1;
    s_wvalid_i <= 1;
    s_bready_i <= 1;
    do begin
      @(posedge mclk_i);
      if (s_awvalid_i && s_awready_o) s_awvalid_i <= 0;
      if (s_wvalid_i && s_wready_o) s_wvalid_i <= 0;
      b = s_bvalid_o;
      r = s_bresp_o;
    end while (!b);
    s_bready_i <= 0;
    @(posedge mclk_i);
    chk({30'h0, r}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [15:0] i, input logic [31:0] e, input logic [1:0] er);
    logic b;
    logic [31:0] d;
    logic [1:0] r;
    s_araddr_i <= {14'h0, i, 2'h0};
    s_arvalid_i <= 1;
    s_rready_i <= 1;
    do begin
      @(posedge mclk_i);
      if (s_arvalid_i && s_arready_o) s_arvalid_i <= 0;
      b = s_rvalid_o;
      d = s_rdata_o;
      r = s_rresp_o;
    end while (!b);
    s_rready_i <= 0;
    @(posedge mclk_i);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask : rd
  task automatic silent;
    logic [31:0] k;
    k = rises;
    cyc(300);
    chk(rises, k);
    chk({31'h0, buzzer_o}, 32'h0);
  endtask : silent
  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd(CTL, 0, OK);
    rd(FRQ, 0, OK);
    rd(VOL, 0, OK);
    rd(GTE, 0, OK);
    chk({31'h0, buzzer_o}, 32'h0);
  endtask : t_reset
  task automatic t_regs;
    wr(FRQ, 8'hff, OK);
    rd(FRQ, 7, OK);
    wr(VOL, 8'hfa, OK);
    rd(VOL, 2, OK);
    wr(16'h5183, 8'h01, DE);
    rd(16'h5183, 0, DE);
  endtask : t_regs
  task automatic t_tones;
    logic [31:0] k, m, b;
    wr(GTE, 1, OK);
    wr(CTL, 1, OK);
    for (int c = 0; c < 8; c++) begin
      wr(FRQ, 8'(c), OK);
      wr(VOL, 8'(c), OK);
      k = rises;
      while (rises < k + 3) @(posedge mclk_i);
      m = (c > 3) ? 2 : 1;
      b = (c % 4 > 1) ? 12 : 8;
      chk(per, SD * m * (16 + 4 * (c % 4)));
      chk(hi, SD * m * (b - c));
    end
    wr(GTE, 0, OK);
    silent;
    wr(GTE, 1, OK);
    wr(CTL, 0, OK);
    silent;
    wr(FRQ, 0, OK);
    wr(VOL, 0, OK);
  endtask : t_tones
  task automatic t_oneshot;
    logic [31:0] k;
    wr(CTL, 8'h05, OK);
    rd(CTL, 5, OK);
    cyc(2000);
    wr(CTL, 8'h05, OK);
    k = rises;
    cyc(3000);
    chk({31'h0, rises > k}, 1);
    rd(CTL, 5, OK);
    cyc(1500);
    rd(CTL, 4, OK);
    silent;
    wr(CTL, 8'h05, OK);
    cyc(100);
    wr(CTL, 8'h04, OK);
    rd(CTL, 4, OK);
    silent;
    wr(CTL, 8'h15, OK);
    cyc(6000);
    rd(CTL, 8'h15, OK);
    cyc(2500);
    rd(CTL, 8'h14, OK);
  endtask : t_oneshot
  task automatic t_env;
    wr(VOL, 7, OK);
    wr(CTL, 8'h09, OK);
    cyc(200);
    chk(hi, SD * 8);
    cyc(4096);
    chk(hi, SD * 7);
    wr(CTL, 8'h09, OK);
    cyc(200);
    chk(hi, SD * 8);
    cyc(7 * 4096);
    chk(hi, SD);
    rd(CTL, 9, OK);
    cyc(4096);
    rd(CTL, 8, OK);
    silent;
    wr(CTL, 8'h09, OK);
    cyc(100);
    wr(CTL, 8'h08, OK);
    silent;
  endtask : t_env
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    cyc(20);
    rst_i <= 0;
    cyc(1);
    t_reset;
    t_regs;
    t_tones;
    t_oneshot;
    t_env;
    tally_and_finish;
  end
  initial begin
    cyc(100000);
    errors++;
    tally_and_finish;
  end
endmodule : tb_buzzer_tone_generator
`default_nettype wire
